// file: src/lbrc_pkg.sv
// Package: constants, types and register map of the LIN bit-rate configuration block
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package lbrc_pkg;
    // Direct register select
    localparam logic [1:0] SEL_CONFIG = 2'h0;
    localparam logic [1:0] SEL_INDEX  = 2'h1;
    localparam logic [1:0] SEL_DATA   = 2'h2;
    // Indirect indices
    localparam logic [7:0] IDX_CONTROL    = 8'h08;
    localparam logic [7:0] IDX_FRAME_SIZE = 8'h0B;
    localparam logic [7:0] IDX_DIV_LOW    = 8'h0C;
    localparam logic [7:0] IDX_MULTIPLIER = 8'h0D;
    // Field positions
    localparam int CFG_ACTIVE_BIT   = 7;
    localparam int CFG_MASTER_BIT   = 6;
    localparam int SIZE_ENHANCED_BIT = 7;
    localparam logic [7:0] CTRL_CLEAR_CODE = 8'h0C;
    localparam logic [8:0] DIV_MIN = 9'h0C8;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] CYC_PER_CLK = 2'h1;

    typedef struct packed {
        logic [1:0] baud_prescale_field;
        logic [4:0] baud_multiplier_field;
        logic       divider_top_bit;
    } lbrc_mul_s;

    typedef struct packed {
        logic [1:0] prescale;
        logic [4:0] multiplier;
        logic [8:0] divider;
        logic       master;
    } lbrc_rate_s;
endpackage : lbrc_pkg

// file: src/lbrc_rate_gen.sv
// Bit-rate tick generator: prescaler, multiplier and divider chain
`timescale 1ns/100ps
module lbrc_rate_gen (
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    // Settings
    input  wire logic              enable_i,
    input  wire lbrc_pkg::lbrc_rate_s cfg_i,
    // Tick
    output logic                   tick_o
);
    logic [3:0] pre_cnt_reg;
    logic [4:0] mul_cnt_reg;
    logic [8:0] div_cnt_reg;
    logic [3:0] pre_last;
    logic [4:0] mul_last;
    logic       pre_wrap;
    logic       mul_wrap;
    logic       div_wrap;

    // Prescale 2^(p+1) and multiplier terminal counts
    always_comb begin
        pre_last = 4'((5'h02 << cfg_i.prescale) - 5'h01);
        mul_last = cfg_i.master ? cfg_i.multiplier : 5'h00;
        pre_wrap = (pre_cnt_reg == pre_last);
        mul_wrap = pre_wrap && (mul_cnt_reg == mul_last);
        div_wrap = mul_wrap && (div_cnt_reg >= cfg_i.divider - 9'h001);
    end

    // Cascaded counters, held clear while inactive
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_cnt_reg <= 4'h0;
            mul_cnt_reg <= 5'h00;
            div_cnt_reg <= 9'h000;
            tick_o      <= 1'b0;
        end else if (!enable_i) begin
            pre_cnt_reg <= 4'h0;
            mul_cnt_reg <= 5'h00;
            div_cnt_reg <= 9'h000;
            tick_o      <= 1'b0;
        end else begin
            pre_cnt_reg <= pre_wrap ? 4'h0 : pre_cnt_reg + 4'h1;
            if (pre_wrap)
                mul_cnt_reg <= mul_wrap ? 5'h00 : mul_cnt_reg + 5'h01;
            if (mul_wrap)
                div_cnt_reg <= div_wrap ? 9'h000 : div_cnt_reg + 9'h001;
            tick_o <= div_wrap;
        end
    end

    // Tick spacing in master mode with the smallest legal chain; counters restart at each wrap
    a_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (tick_o && enable_i && cfg_i.master && cfg_i.prescale == 2'h0 && cfg_i.multiplier == 5'h00
         && cfg_i.divider == lbrc_pkg::DIV_MIN && $stable(cfg_i))
        |=> !tick_o [*8]) else $error("tick too early");
endmodule : lbrc_rate_gen

// file: src/lbrc_top.sv
// Top: indirect register file and bit-rate configuration of the LIN controller
`timescale 1ns/100ps
module lbrc_top (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    // Register port from the CPU
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [1:0]  reg_sel_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    // Settings to the rest of the controller
    output logic             link_active_o,
    output logic             master_mode_o,
    output logic             enhanced_csum_o,
    output logic             clear_pulse_o,
    output logic      [8:0]  divider_o,
    output logic             bit_tick_o
);
    //------------------------------------------------------------------
    // Register state
    //------------------------------------------------------------------
    logic [7:0]          link_config_reg;
    logic [7:0]          indirect_index_reg;
    lbrc_pkg::lbrc_mul_s baud_multiplier_prescale_reg;
    logic [7:0]          divider_low_reg;
    logic [7:0]          frame_size_reg;
    logic [7:0]          link_control_reg;
    logic                data_wr;
    lbrc_pkg::lbrc_rate_s rate_cfg;
    logic                rate_tick;

    // Data writes target the indexed location
    assign data_wr = reg_wr_i && (reg_sel_i == lbrc_pkg::SEL_DATA);

    // Indexed location read decode
    function automatic logic [7:0] read_indexed(input logic [7:0] idx, input logic [7:0] mul,
                                                input logic [7:0] dl, input logic [7:0] fs,
                                                input logic [7:0] ct);
        case (idx)
            lbrc_pkg::IDX_MULTIPLIER: read_indexed = mul;
            lbrc_pkg::IDX_DIV_LOW:    read_indexed = dl;
            lbrc_pkg::IDX_FRAME_SIZE: read_indexed = fs;
            lbrc_pkg::IDX_CONTROL:    read_indexed = ct;
            default:                  read_indexed = 8'h00;
        endcase
    endfunction : read_indexed

    //------------------------------------------------------------------
    // Direct registers
    //------------------------------------------------------------------
    // Config and index are written directly
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_config_reg    <= lbrc_pkg::RST_BYTE;
            indirect_index_reg <= lbrc_pkg::RST_BYTE;
        end else if (reg_wr_i) begin
            if (reg_sel_i == lbrc_pkg::SEL_CONFIG)
                link_config_reg <= reg_wdata_i;
            if (reg_sel_i == lbrc_pkg::SEL_INDEX)
                indirect_index_reg <= reg_wdata_i;
        end
    end

    //------------------------------------------------------------------
    // Indirect registers
    //------------------------------------------------------------------
    // Multiplier and divider fields
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            baud_multiplier_prescale_reg <= lbrc_pkg::RST_BYTE;
            divider_low_reg              <= lbrc_pkg::RST_BYTE;
        end else if (data_wr) begin
            if (indirect_index_reg == lbrc_pkg::IDX_MULTIPLIER)
                baud_multiplier_prescale_reg <= reg_wdata_i;
            if (indirect_index_reg == lbrc_pkg::IDX_DIV_LOW)
                divider_low_reg <= reg_wdata_i;
        end
    end

    // Frame size keeps all bits; bit 7 picks the checksum
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            frame_size_reg <= lbrc_pkg::RST_BYTE;
        else if (data_wr && indirect_index_reg == lbrc_pkg::IDX_FRAME_SIZE)
            frame_size_reg <= reg_wdata_i;
    end

    // Control is command-like; only the clear code acts here
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_control_reg <= lbrc_pkg::RST_BYTE;
            clear_pulse_o    <= 1'b0;
        end else begin
            clear_pulse_o <= data_wr && indirect_index_reg == lbrc_pkg::IDX_CONTROL
                             && reg_wdata_i == lbrc_pkg::CTRL_CLEAR_CODE;
            if (data_wr && indirect_index_reg == lbrc_pkg::IDX_CONTROL)
                link_control_reg <= reg_wdata_i & ~lbrc_pkg::CTRL_CLEAR_CODE; // Clear bits self-reset
        end
    end

    //------------------------------------------------------------------
    // Read path and outputs
    //------------------------------------------------------------------
    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i) begin
            case (reg_sel_i)
                lbrc_pkg::SEL_CONFIG: reg_rdata_o <= link_config_reg;
                lbrc_pkg::SEL_INDEX:  reg_rdata_o <= indirect_index_reg;
                lbrc_pkg::SEL_DATA:   reg_rdata_o <= read_indexed(indirect_index_reg,
                                          baud_multiplier_prescale_reg, divider_low_reg,
                                          frame_size_reg, link_control_reg);
                default:              reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Assembled rate settings; divider range 200..511 is software's duty
    always_comb begin
        rate_cfg.prescale   = baud_multiplier_prescale_reg.baud_prescale_field;
        rate_cfg.multiplier = baud_multiplier_prescale_reg.baud_multiplier_field;
        rate_cfg.divider    = {baud_multiplier_prescale_reg.divider_top_bit, divider_low_reg};
        rate_cfg.master     = link_config_reg[lbrc_pkg::CFG_MASTER_BIT];
    end

    // Registered settings outputs
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_active_o   <= 1'b0;
            master_mode_o   <= 1'b0;
            enhanced_csum_o <= 1'b0;
            divider_o       <= 9'h000;
            bit_tick_o      <= 1'b0;
        end else begin
            link_active_o   <= link_config_reg[lbrc_pkg::CFG_ACTIVE_BIT];
            master_mode_o   <= link_config_reg[lbrc_pkg::CFG_MASTER_BIT];
            enhanced_csum_o <= frame_size_reg[lbrc_pkg::SIZE_ENHANCED_BIT];
            divider_o       <= rate_cfg.divider;
            bit_tick_o      <= rate_tick;
        end
    end

    // Rate chain runs only while active; low divisors are software's concern
    lbrc_rate_gen u_rate_gen (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .enable_i  (link_config_reg[lbrc_pkg::CFG_ACTIVE_BIT]),
        .cfg_i     (rate_cfg),
        .tick_o    (rate_tick)
    );

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    a_active_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_wr_i && reg_sel_i == lbrc_pkg::SEL_CONFIG
        |=> ##1 link_active_o == $past(reg_wdata_i[lbrc_pkg::CFG_ACTIVE_BIT], 2))
        else $error("active bit wrong");
    a_master_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_wr_i && reg_sel_i == lbrc_pkg::SEL_CONFIG
        |=> ##1 master_mode_o == $past(reg_wdata_i[lbrc_pkg::CFG_MASTER_BIT], 2))
        else $error("master bit wrong");
    a_clear_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        data_wr && indirect_index_reg == lbrc_pkg::IDX_CONTROL && reg_wdata_i == lbrc_pkg::CTRL_CLEAR_CODE
        |=> clear_pulse_o) else $error("clear missed");
    a_clear_only_cmd: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        clear_pulse_o |-> $past(data_wr && indirect_index_reg == lbrc_pkg::IDX_CONTROL))
        else $error("spurious clear");
    a_mul_fields: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        data_wr && indirect_index_reg == lbrc_pkg::IDX_MULTIPLIER |=> rate_cfg.prescale == $past(reg_wdata_i[7:6])
        && rate_cfg.multiplier == $past(reg_wdata_i[5:1])) else $error("mul fields");
    a_div_assembly: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        data_wr && indirect_index_reg == lbrc_pkg::IDX_DIV_LOW
        |=> ##1 divider_o[7:0] == $past(reg_wdata_i, 2)) else $error("divider low");
    a_div_top: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        data_wr && indirect_index_reg == lbrc_pkg::IDX_MULTIPLIER
        |=> ##1 divider_o[8] == $past(reg_wdata_i[0], 2)) else $error("divider top");
    a_enh_csum: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        data_wr && indirect_index_reg == lbrc_pkg::IDX_FRAME_SIZE
        |=> ##1 enhanced_csum_o == $past(reg_wdata_i[lbrc_pkg::SIZE_ENHANCED_BIT], 2))
        else $error("checksum bit");
    a_read_mul: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_rd_i && reg_sel_i == lbrc_pkg::SEL_DATA && indirect_index_reg == lbrc_pkg::IDX_MULTIPLIER && !reg_wr_i
        |=> reg_rdata_o == $past(baud_multiplier_prescale_reg)) else $error("indirect read");
    a_inactive_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !link_config_reg[lbrc_pkg::CFG_ACTIVE_BIT] [*3] |-> !bit_tick_o) else $error("tick while inactive");
endmodule : lbrc_top

// file: bench/lbrc_tick_sink.sv
// Far-side model: consumer of the bit tick that measures the bit period
`timescale 1ns/100ps
module lbrc_tick_sink (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // Bit tick from the generator
    input  wire logic tick_i,
    // Measurements
    output int        period_o,
    output int        ticks_o
);
    int gap_reg;

    // Cycles between ticks; the last gap is taken as the bit period
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_reg  <= 0;
            period_o <= 0;
            ticks_o  <= 0;
        end else if (tick_i === 1'b1) begin
            period_o <= gap_reg + 1;
            gap_reg  <= 0;
            ticks_o  <= ticks_o + 1;
        end else begin
            gap_reg  <= gap_reg + 1;
        end
    end
endmodule : lbrc_tick_sink

// file: bench/tb_top.sv
// Testbench: indirect registers, settings outputs and bit period
`timescale 1ns/100ps
module tb_top;
    logic       clk_sys_i   = 1'b0;
    logic       rst_n_i     = 1'b0;
    logic       reg_wr_i    = 1'b0;
    logic       reg_rd_i    = 1'b0;
    logic [1:0] reg_sel_i   = 2'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic       link_active_o, master_mode_o, enhanced_csum_o, clear_pulse_o, bit_tick_o;
    logic [8:0] divider_o;
    logic [7:0] rd;
    int         period, ticks, errors = 0, samples_checked = 0, clears = 0;

    //----------------------------------------------------------------------
    // Clock, design and far side
    //----------------------------------------------------------------------
    always #5 clk_sys_i = ~clk_sys_i;

    lbrc_top lbrc_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_sel_i(reg_sel_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .link_active_o(link_active_o), .master_mode_o(master_mode_o), .enhanced_csum_o(enhanced_csum_o),
        .clear_pulse_o(clear_pulse_o), .divider_o(divider_o), .bit_tick_o(bit_tick_o));

    lbrc_tick_sink lbrc_tick_sink_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .tick_i(bit_tick_o),
        .period_o(period), .ticks_o(ticks));

    // Count clear pulses so their exact number can be judged
    always @(posedge clk_sys_i) if (clear_pulse_o === 1'b1) clears <= clears + 1;

    //----------------------------------------------------------------------
    // Shared tasks
    //----------------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b1;
        reg_sel_i   <= sel;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    // Read data is registered, so it is taken just after the read edge
    task automatic rdr(input logic [1:0] sel, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_rd_i  <= 1'b1;
        reg_sel_i <= sel;
        @(posedge clk_sys_i);
        reg_rd_i  <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rdr

    task automatic put(input logic [7:0] idx, input logic [7:0] d);
        wr(lbrc_pkg::SEL_INDEX, idx);
        wr(lbrc_pkg::SEL_DATA, d);
    endtask : put

    task automatic get(input logic [7:0] idx, output logic [7:0] d);
        wr(lbrc_pkg::SEL_INDEX, idx);
        rdr(lbrc_pkg::SEL_DATA, d);
    endtask : get

    // Settings need two edges to reach the outputs
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask : settle

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    //----------------------------------------------------------------------
    // Scenarios
    //----------------------------------------------------------------------
    task automatic test_regs();
        chk(link_active_o | master_mode_o | enhanced_csum_o, 16'h0, "reset outputs");
        get(lbrc_pkg::IDX_MULTIPLIER, rd);
        chk(rd, 16'h0, "multiplier reset");
        wr(lbrc_pkg::SEL_CONFIG, 8'h80);
        settle();
        chk(link_active_o, 16'h1, "active");
        chk(master_mode_o, 16'h0, "slave");
        wr(lbrc_pkg::SEL_CONFIG, 8'hC0);
        settle();
        chk(master_mode_o, 16'h1, "master");
        put(lbrc_pkg::IDX_MULTIPLIER, 8'hBB);
        put(lbrc_pkg::IDX_DIV_LOW, 8'h3F);
        get(lbrc_pkg::IDX_MULTIPLIER, rd);
        chk(rd, 16'hBB, "multiplier readback");
        settle();
        chk(divider_o, 16'h13F, "divider join");
        get(lbrc_pkg::IDX_DIV_LOW, rd);
        chk(rd, 16'h3F, "divider low readback");
        put(8'h05, 8'hFF);
        get(8'h05, rd);
        chk(rd, 16'h0, "unmapped index");
        rdr(2'h3, rd);
        chk(rd, 16'h0, "unused select");
        $display("test_regs done");
    endtask : test_regs

    task automatic test_csum_clear();
        int n;
        put(lbrc_pkg::IDX_FRAME_SIZE, 8'h80);
        settle();
        chk(enhanced_csum_o, 16'h1, "enhanced on");
        put(lbrc_pkg::IDX_FRAME_SIZE, 8'h00);
        settle();
        chk(enhanced_csum_o, 16'h0, "enhanced off");
        n = clears;
        put(lbrc_pkg::IDX_CONTROL, 8'h07);
        settle();
        chk(16'(clears - n), 16'h0, "no clear on other code");
        get(lbrc_pkg::IDX_CONTROL, rd);
        chk(rd, 16'h03, "control readback");
        put(lbrc_pkg::IDX_CONTROL, 8'h0C);
        settle();
        chk(16'(clears - n), 16'h1, "one clear pulse");
        $display("test_csum_clear done");
    endtask : test_csum_clear

    // Divider values stay in 200..511 and prescale/multiplier per example table
    task automatic test_rates();
        logic [7:0]  cfg[4] = '{8'hC0, 8'h80, 8'hC0, 8'hC0};
        logic [7:0]  mul[4] = '{8'h44, 8'h44, 8'h01, 8'h00};
        logic [7:0]  low[4] = '{8'hC8, 8'hC8, 8'h2C, 8'hC8};
        logic [15:0] exp[4] = '{16'd2400, 16'd800, 16'd600, 16'd400};
        int n;
        // Last setting is the shortest legal chain, so the spacing check sees it
        for (int k = 0; k < 4; k++) begin
            wr(lbrc_pkg::SEL_CONFIG, cfg[k]);
            put(lbrc_pkg::IDX_MULTIPLIER, mul[k]);
            put(lbrc_pkg::IDX_DIV_LOW, low[k]);
            settle();
            n = ticks + 3;
            for (int i = 0; i < 10000 && ticks < n; i++) @(posedge clk_sys_i);
            chk(16'(period), exp[k], "bit period");
        end
        wr(lbrc_pkg::SEL_CONFIG, 8'h00);
        settle();
        n = ticks;
        repeat (3000) @(posedge clk_sys_i);
        chk(16'(ticks - n), 16'h0, "no tick when inactive");
        $display("test_rates done");
    endtask : test_rates

    //----------------------------------------------------------------------
    // Main sequence and watchdog
    //----------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1;
        test_regs();
        test_csum_clear();
        test_rates();
        complete_run();
    end

    // Whole run is about 16000 cycles; this cuts a hang well beyond that
    initial begin
        #800us;
        errors++;
        $display("BAD t=%0t watchdog expired", $time);
        complete_run();
    end
endmodule : tb_top
